// ===== hw/altcr_top.sv
// Purpose: serial port with low alarm limit bank and command echo
// Assumes: cs_n, sclk, sdi asynchronous; sclk far slower than clock
// Notes: word is addr[15:9], write[8], data[7:0], MSB first
//
// Overview of operation
// - channel 0 upper low-limit byte at 0x18, read/write, resets to zero
// - channel 0 lower low-limit byte at 0x19, read/write, resets to zero
// - limit byte pair repeated for each channel, CH_COUNT of them, eight by default
// - effective low limit is upper byte over lower byte
// - echo command returns the upper command byte executed in the previous frame
// - echo leaves on sdo from the 16th falling edge, MSB first
// - echo carries data in first eight bits, then eight zeros
// - echo register is read-only, holds previous upper command byte
`timescale 1ns/1ps
module altcr_top #(
  parameter int CH_COUNT = altcr_pkg::NUM_CH
) (
  // clocking
  input wire logic clock,
  input wire logic reset,
  input wire logic ce,
  // serial port pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  // limits to the alarm comparator
  output logic [16*CH_COUNT-1:0] low_alarm_limit
);
  logic [2:0] cs_n_sync_reg;
  logic [2:0] sclk_sync_reg;
  logic [1:0] sdi_sync_reg;
  logic [5:0] rcnt_reg;
  logic [5:0] fcnt_reg;
  logic [15:0] rx_reg;
  logic [15:0] tx_reg;
  logic sdo_reg;
  logic [7:0] cmd_reg;
  logic cmd_valid_reg;
  logic [7:0] echo_reg;
  logic [CH_COUNT-1:0] ch_hit;
  logic [7:0] ch_rdata [CH_COUNT];
  logic [7:0] thr_rdata;
  logic [15:0] word_next;

  // ****************************************************************
  // pin synchronisers and edge detect
  // ****************************************************************
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      cs_n_sync_reg <= 3'h7;
      sclk_sync_reg <= 3'h0;
      sdi_sync_reg <= 2'h0;
    end
    else if (ce)
    begin
      cs_n_sync_reg <= {cs_n_sync_reg[1:0], cs_n};
      sclk_sync_reg <= {sclk_sync_reg[1:0], sclk};
      sdi_sync_reg <= {sdi_sync_reg[0], sdi};
    end
  end

  wire active = ce & ~cs_n_sync_reg[1];
  wire frame_start = ce & ~cs_n_sync_reg[1] & cs_n_sync_reg[2];
  wire frame_end = ce & cs_n_sync_reg[1] & ~cs_n_sync_reg[2];
  wire sclk_rise = active & sclk_sync_reg[1] & ~sclk_sync_reg[2];
  wire sclk_fall = active & ~sclk_sync_reg[1] & sclk_sync_reg[2];
  wire word_done = sclk_rise && rcnt_reg == altcr_pkg::LAST_RX_EDGE;
  wire tx_edge = sclk_fall && fcnt_reg >= altcr_pkg::FIRST_TX_EDGE;

  // ****************************************************************
  // word decode
  // ****************************************************************
  assign word_next = {rx_reg[14:0], sdi_sync_reg[1]};
  wire [6:0] w_addr = word_next[altcr_pkg::ADDR_MSB:altcr_pkg::ADDR_LSB];
  wire w_write = word_next[altcr_pkg::WRITE_BIT];
  wire [7:0] w_data = word_next[7:0];
  wire is_echo = !w_write && w_addr == altcr_pkg::ECHO_ADDR;
  wire thr_write = word_done & w_write;
  wire [7:0] resp = is_echo ? echo_reg : thr_rdata;

  // ****************************************************************
  // channel limit bank
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < CH_COUNT; gi++)
    begin : g_ch
      altcr_limit_pair #(.CH_IDX(7'(gi))) u_pair (
        .clock(clock),
        .reset(reset),
        .ce(ce),
        .wr_en(thr_write),
        .addr(w_addr),
        .wdata(w_data),
        .hit(ch_hit[gi]),
        .rdata(ch_rdata[gi]),
        .limit(low_alarm_limit[16*gi +: 16])
      );
    end
  endgenerate

  always_comb
  begin
    thr_rdata = 8'h00;
    for (int i = 0; i < CH_COUNT; i++)
      thr_rdata = thr_rdata | ch_rdata[i];
  end

  // ****************************************************************
  // frame counters and receive
  // ****************************************************************
  always_ff @(posedge clock)
  begin
    if (reset || frame_start)
    begin
      rcnt_reg <= 6'h00;
      fcnt_reg <= 6'h00;
      rx_reg <= 16'h0000;
    end
    else
    begin
      if (sclk_rise && rcnt_reg != altcr_pkg::EDGE_SAT)
        rcnt_reg <= rcnt_reg + 6'h01;
      if (sclk_fall && fcnt_reg != altcr_pkg::EDGE_SAT)
        fcnt_reg <= fcnt_reg + 6'h01;
      if (sclk_rise && rcnt_reg <= altcr_pkg::LAST_RX_EDGE)
        rx_reg <= word_next;
    end
  end

  // ****************************************************************
  // command capture and echo
  // ****************************************************************
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      cmd_reg <= altcr_pkg::ECHO_RESET;
      cmd_valid_reg <= 1'b0;
      echo_reg <= altcr_pkg::ECHO_RESET;
    end
    else if (frame_start)
      cmd_valid_reg <= 1'b0;
    else if (word_done)
    begin
      cmd_reg <= word_next[15:8];
      cmd_valid_reg <= 1'b1;
    end
    else if (frame_end && cmd_valid_reg)
      echo_reg <= cmd_reg;
  end

  // ****************************************************************
  // transmit
  // ****************************************************************
  always_ff @(posedge clock)
  begin
    if (reset || frame_start)
    begin
      tx_reg <= 16'h0000;
      sdo_reg <= 1'b0;
    end
    else if (word_done)
      tx_reg <= {resp, altcr_pkg::PAD_BYTE};
    else if (tx_edge)
    begin
      sdo_reg <= tx_reg[15];
      tx_reg <= {tx_reg[14:0], 1'b0};
    end
    else if (frame_end)
      sdo_reg <= 1'b0;
  end

  assign sdo = sdo_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_echo_req;
    word_done && is_echo;
  endsequence
  sequence s_first_tx;
    tx_edge && fcnt_reg == altcr_pkg::FIRST_TX_EDGE;
  endsequence

  chk_echo_load: assert property (
    s_echo_req |=> tx_reg == {$past(echo_reg), 8'h00})
    else $error("echo word not loaded");
  chk_read_limit: assert property (
    word_done && !w_write && |ch_hit |=> tx_reg[15:8] == $past(thr_rdata))
    else $error("limit read data not loaded");
  chk_sdo_first: assert property (
    s_first_tx |=> sdo == $past(tx_reg[15]))
    else $error("first echo bit not on sdo");
  chk_sdo_early: assert property (
    sclk_fall && fcnt_reg < altcr_pkg::FIRST_TX_EDGE |=> sdo == 1'b0)
    else $error("sdo driven before 16th falling edge");
  chk_pad_zero: assert property (
    tx_edge && fcnt_reg >= altcr_pkg::PAD_TX_EDGE |=> sdo == 1'b0)
    else $error("pad bits not zero");
  chk_echo_update: assert property (
    frame_end && cmd_valid_reg && !frame_start
      |=> echo_reg == $past(cmd_reg))
    else $error("echo not updated at frame end");
  chk_echo_hold: assert property (
    !(frame_end && cmd_valid_reg) |=> $stable(echo_reg))
    else $error("echo changed outside frame end");
  chk_echo_ro: assert property (
    thr_write && w_addr == altcr_pkg::ECHO_ADDR |-> ch_hit == '0)
    else $error("write to echo address hit a limit");
  chk_one_channel: assert property (
    thr_write |-> $onehot0(ch_hit))
    else $error("write hit more than one channel");
  chk_sdo_idle: assert property (
    frame_end |=> sdo == 1'b0)
    else $error("sdo not back to zero after frame");
endmodule

// ===== hw/altcr_pkg.sv
// Purpose: constants for the low alarm limit bank and command echo
// Assumes: 7-bit register addresses, 16-bit serial words
// Notes: one channel block spans five addresses
package altcr_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [6:0] UPPER_BASE = 7'h18;
  localparam logic [6:0] LOWER_BASE = 7'h19;
  localparam logic [6:0] CH_STRIDE = 7'h05;
  localparam logic [6:0] ECHO_ADDR = 7'h3f;
  localparam logic [7:0] LIMIT_RESET = 8'h00;
  localparam logic [7:0] ECHO_RESET = 8'h00;
  localparam logic [7:0] PAD_BYTE = 8'h00;
  // ****************************************************************
  // word layout and frame timing
  // ****************************************************************
  localparam int ADDR_MSB = 15;
  localparam int ADDR_LSB = 9;
  localparam int WRITE_BIT = 8;
  localparam logic [5:0] LAST_RX_EDGE = 6'h0f;
  localparam logic [5:0] FIRST_TX_EDGE = 6'h0f;
  localparam logic [5:0] PAD_TX_EDGE = 6'h17;
  localparam logic [5:0] EDGE_SAT = 6'h3f;
  localparam int NUM_CH = 8;
endpackage

// ===== hw/altcr_limit_pair.sv
// Purpose: one channel's upper and lower low alarm limit bytes
// Assumes: write strobe and address come from the frame decoder
// Notes: read data is combinational, gated by the address hit
`timescale 1ns/1ps
module altcr_limit_pair #(
  parameter logic [6:0] CH_IDX = 7'h00
) (
  // clocking
  input wire logic clock,
  input wire logic reset,
  input wire logic ce,
  // register access
  input wire logic wr_en,
  input wire logic [6:0] addr,
  input wire logic [7:0] wdata,
  output logic hit,
  output logic [7:0] rdata,
  // limit to the alarm comparator
  output logic [15:0] limit
);
  logic [7:0] upper_reg;
  logic [7:0] lower_reg;
  logic [6:0] my_upper;
  logic [6:0] my_lower;
  wire hit_upper;
  wire hit_lower;

  // ****************************************************************
  // decode
  // ****************************************************************
  assign my_upper = 7'(altcr_pkg::UPPER_BASE + altcr_pkg::CH_STRIDE * CH_IDX);
  assign my_lower = 7'(altcr_pkg::LOWER_BASE + altcr_pkg::CH_STRIDE * CH_IDX);
  assign hit_upper = addr == my_upper;
  assign hit_lower = addr == my_lower;
  assign hit = hit_upper | hit_lower;
  assign rdata = hit_upper ? upper_reg : (hit_lower ? lower_reg : 8'h00);
  assign limit = {upper_reg, lower_reg};

  // ****************************************************************
  // storage
  // ****************************************************************
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      upper_reg <= altcr_pkg::LIMIT_RESET;
      lower_reg <= altcr_pkg::LIMIT_RESET;
    end
    else if (ce && wr_en)
    begin
      if (hit_upper)
        upper_reg <= wdata;
      if (hit_lower)
        lower_reg <= wdata;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  chk_upper_write: assert property (
    ce && wr_en && hit_upper |=> limit[15:8] == $past(wdata))
    else $error("upper limit byte not written");
  chk_lower_write: assert property (
    ce && wr_en && hit_lower |=> limit[7:0] == $past(wdata))
    else $error("lower limit byte not written");
  chk_upper_kept: assert property (
    ce && wr_en && hit_lower |=> limit[15:8] == $past(limit[15:8]))
    else $error("lower write disturbed upper byte");
  chk_limit_stable: assert property (
    !(ce && wr_en && hit) |=> $stable(limit))
    else $error("limit changed without own write");
endmodule

// ===== bench/altcr_host_model.sv
// Purpose: host model driving the serial port of the limit bank
// Assumes: clock period 100 ns, sclk period 800 ns, sclk idles low
// Notes: sclk low 5 clocks then high 3; sdo sampled before each rise from the 17th
`timescale 1ns/1ps
module altcr_host_model (
  // clocking
  input wire logic clock,
  // serial port pins
  output logic cs_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo
);
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n)
    begin
      @(posedge clock);
      #1;
    end
  endtask
  // one frame of n sclk cycles; bits after the word are zero
  task automatic frame(input logic [15:0] w, input int n,
    output logic [15:0] r);
    r = 16'h0000;
    cs_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      sdi = (i < 16) ? w[15-i] : 1'b0;
      wait_clk(5);
      if (i >= 16)
        r[31-i] = sdo;
      sclk = 1'b1;
      wait_clk(3);
      sclk = 1'b0;
    end
    wait_clk(2);
    cs_n = 1'b1;
    // released line must not keep its last value
    sdi = ~sdi;
    wait_clk(6);
  endtask
endmodule

// ===== bench/alarm_low_threshold_and_cmd_readback_tb_top.sv
// Purpose: self-checking bench for the low limit bank and echo
// Assumes: host model drives the serial port, ce held high except for one frame
// Notes: limit frame words use the package constants, echo frames the literal 16'h7e00; expected limits are built from up and lo
`timescale 1ns/1ps
module alarm_low_threshold_and_cmd_readback_tb_top;
  logic clock;
  logic reset;
  logic ce;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic sdo;
  logic [127:0] low_alarm_limit;
  logic [127:0] exp_lim;
  logic [15:0] r;
  logic [7:0] up;
  logic [7:0] lo;
  int miscompares;
  int samples_checked;
  int cycles;
  altcr_top #(
    .CH_COUNT(8)
  ) i_altcr_top (
    .clock(clock),
    .reset(reset),
    .ce(ce),
    .cs_n(cs_n),
    .sclk(sclk),
    .sdi(sdi),
    .sdo(sdo),
    .low_alarm_limit(low_alarm_limit)
  );
  altcr_host_model i_altcr_host_model (
    .clock(clock),
    .cs_n(cs_n),
    .sclk(sclk),
    .sdi(sdi),
    .sdo(sdo)
  );
  // ****************************************************************
  // clock, timeout and reporting
  // ****************************************************************
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
      miscompares++;
    end
  endtask
  // ****************************************************************
  // tests
  // ****************************************************************
  initial
  begin
    reset = 1'b1;
    ce = 1'b1;
    miscompares = 0;
    samples_checked = 0;
    cycles = 0;
    exp_lim = 128'h0;
    repeat (10) @(posedge clock);
    #1 reset = 1'b0;
    i_altcr_host_model.wait_clk(6);
    chk(low_alarm_limit, exp_lim);
    i_altcr_host_model.frame(16'h7e00, 24, r);
    chk(128'(r[15:8]), 128'h0);
    i_altcr_host_model.frame({altcr_pkg::UPPER_BASE, 9'h000}, 24, r);
    chk(128'(r[15:8]), 128'h0);
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      up = 8'ha0 + 8'(i);
      lo = 8'h50 + 8'(i);
      i_altcr_host_model.frame({altcr_pkg::UPPER_BASE +
        altcr_pkg::CH_STRIDE * 7'(i), 1'b1, up}, 16, r);
      i_altcr_host_model.frame({altcr_pkg::LOWER_BASE +
        altcr_pkg::CH_STRIDE * 7'(i), 1'b1, lo}, 16, r);
      exp_lim[16*i+:16] = {up, lo};
      chk(low_alarm_limit, exp_lim);
    end
    i_altcr_host_model.frame({altcr_pkg::UPPER_BASE, 9'h000}, 24, r);
    chk(128'(r[15:8]), 128'ha0);
    i_altcr_host_model.frame({altcr_pkg::LOWER_BASE, 9'h000}, 24, r);
    chk(128'(r[15:8]), 128'h50);
    $display("test limits done");
    i_altcr_host_model.frame(16'h7e00, 32, r);
    chk(128'(r), 128'h3200);
    i_altcr_host_model.frame(16'h7e00, 24, r);
    chk(128'(r[15:8]), 128'h7e);
    $display("test echo done");
    i_altcr_host_model.frame({altcr_pkg::ECHO_ADDR, 9'h155}, 16, r);
    chk(low_alarm_limit, exp_lim);
    // a frame sent while ce is low must leave no trace
    ce = 1'b0;
    i_altcr_host_model.frame({altcr_pkg::UPPER_BASE, 1'b1, 8'h11}, 16, r);
    ce = 1'b1;
    chk(low_alarm_limit, exp_lim);
    i_altcr_host_model.frame(16'h7e00, 24, r);
    chk(128'(r[15:8]), 128'h7f);
    $display("test read only done");
    give_verdict();
  end
endmodule
